// >>> shared/odp_pkg.sv
// Constants for the output divider, phase and buffer control block.
// Assumes one system clock and a classic Wishbone register slave.
package odp_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NDIV   = 8;
    localparam int NOUT   = 10;
    localparam int NRATIO = 26;

    // ------------------------------------------------------------
    // Register word indices (byte address = 4 * index)
    // ------------------------------------------------------------
    localparam logic [3:0] REG_OUT_LAST = 4'h9;
    localparam logic [3:0] REG_CTRL     = 4'hA;
    localparam logic [3:0] REG_STAT     = 4'hB;

    // Output register fields
    localparam int RS_LSB = 0;   // output_ratio_select, 5 bits
    localparam int PH_LSB = 5;   // coarse_phase_select, 7 bits
    localparam int DT_LSB = 12;  // driver type, 2 bits
    localparam int CN_LSB = 22;  // negative single-ended control
    localparam int CP_LSB = 24;  // positive single-ended control

    // Control register fields
    localparam int GO_BIT  = 0;
    localparam int SRC_LSB = 1;
    localparam int RT_BIT  = 3;
    localparam int ALT_BIT = 4;

    // Status register fields
    localparam int ST_BUSY = 0;
    localparam int ST_RHS  = 1;
    localparam int ST_HOLD = 2;
    localparam int ST_LVL  = 8;

    // Reset values and writable masks
    localparam logic [31:0] CFG_RST   = 32'h0000_0000;
    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] CFG_MASK  = 32'h03C0_3FFF;
    localparam logic [31:0] CTRL_MASK = 32'h0000_001E;

    // Driver types
    localparam logic [1:0] DT_OFF  = 2'h0;
    localparam logic [1:0] DT_PECL = 2'h1;
    localparam logic [1:0] DT_LVDS = 2'h2;
    localparam logic [1:0] DT_CMOS = 2'h3;

    // Single-ended driver controls
    localparam logic [1:0] SE_ACT = 2'h0;
    localparam logic [1:0] SE_INV = 2'h1;
    localparam logic [1:0] SE_LOW = 2'h2;
    localparam logic [1:0] SE_HIZ = 2'h3;

    // Sync request sources
    localparam logic [1:0] SRC_SW  = 2'h0;
    localparam logic [1:0] SRC_PIN = 2'h1;
    localparam logic [1:0] SRC_RST = 2'h2;
    localparam logic [1:0] SRC_ANY = 2'h3;

    // Supported divide ratios, indexed by output_ratio_select
    localparam logic [6:0] RATIO_TBL [NRATIO] = '{
        7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h08, 7'h0A,
        7'h0C, 7'h10, 7'h12, 7'h14, 7'h18, 7'h1C, 7'h1E, 7'h20,
        7'h24, 7'h28, 7'h2A, 7'h30, 7'h32, 7'h38, 7'h3C, 7'h40,
        7'h46, 7'h50};

    typedef enum logic [2:0] {
        SY_IDLE = 3'b001,
        SY_ARM  = 3'b010,
        SY_HOLD = 3'b100
    } odp_sync_e;

endpackage

// >>> logic/odp_top.sv
// Output divider, coarse phase adjust, buffer mode and sync logic.
// Assumes the source clock arrives as a level synchronous to sys_clk_in
// and at most a quarter of its rate; registers over classic Wishbone.
`timescale 1ns/10ps
module odp_top (
    input  wire logic        sys_clk_in,
    input  wire logic        resetn_in,
    input  wire logic        src_clk_in,
    input  wire logic        sync_pin_in,
    input  wire logic        rst_hold_n_in,
    input  wire logic        nv_rh_sel_in,
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [7:0]  wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    output logic      [9:0]  clk_lvl_out,
    output logic      [9:0]  pecl_en_out,
    output logic      [9:0]  lvds_en_out,
    output logic      [9:0]  se_p_out,
    output logic      [9:0]  se_p_oe_out,
    output logic      [9:0]  se_n_out,
    output logic      [9:0]  se_n_oe_out,
    output logic             hold_active_out
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [31:0]      cfg_ff [odp_pkg::NOUT];
    logic [31:0]      nxt_cfg [odp_pkg::NOUT];
    logic [31:0]      ctrl_ff;
    logic [31:0]      nxt_ctrl;
    logic             ack_ff;
    logic             nxt_ack;
    logic [31:0]      rdat_ff;
    logic [31:0]      nxt_rdat;
    logic             src_q_ff;
    logic             nxt_src_q;
    logic             pin_q_ff;
    logic             nxt_pin_q;
    logic             rhs_ff;
    logic             nxt_rhs;
    logic             hold_ff;
    logic             nxt_hold;
    odp_pkg::odp_sync_e sy_ff;
    odp_pkg::odp_sync_e nxt_sy;
    logic [6:0]       cnt_ff [odp_pkg::NDIV];
    logic [6:0]       nxt_cnt [odp_pkg::NDIV];
    logic             dlvl_ff [odp_pkg::NDIV];
    logic             nxt_dlvl [odp_pkg::NDIV];
    logic [6:0]       ratio [odp_pkg::NDIV];
    logic             wrap [odp_pkg::NDIV];
    logic             src_rise;
    logic             wr_hit;
    logic [31:0]      wmask;
    logic [3:0]       widx;
    logic             sw_go;
    logic             rst_req;
    logic             sync_req;
    logic             load_ph;
    logic             div_held;
    logic [31:0]      status;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    // Byte lane mask and decoded write strobe
    // Writes land at the edge the master samples ack, not earlier,
    // so a request dropped before its ack never changes state
    always_comb begin
        widx  = wb_adr_in[5:2];
        wmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}},
                 {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
        wr_hit = wb_cyc_in & wb_stb_in & wb_we_in & ack_ff
                 & (wb_adr_in[7:6] == 2'h0);
        sw_go = wr_hit & (widx == odp_pkg::REG_CTRL)
                & wb_sel_in[0] & wb_dat_in[odp_pkg::GO_BIT];
    end

    // Status word: block state visible to software
    always_comb begin
        status = 32'h0000_0000;
        status[odp_pkg::ST_BUSY] = (sy_ff != odp_pkg::SY_IDLE);
        status[odp_pkg::ST_RHS]  = rhs_ff;
        status[odp_pkg::ST_HOLD] = hold_ff;
        status[odp_pkg::ST_LVL +: odp_pkg::NOUT] = clk_lvl_out;
    end

    // Ack one cycle after the request, dropped the cycle after
    always_comb begin
        nxt_ack  = wb_cyc_in & wb_stb_in & ~ack_ff;
        nxt_rdat = 32'h0000_0000;
        if (widx <= odp_pkg::REG_OUT_LAST && wb_adr_in[7:6] == 2'h0) begin
            nxt_rdat = cfg_ff[widx];
        end else if (widx == odp_pkg::REG_CTRL && wb_adr_in[7:6] == 2'h0) begin
            nxt_rdat = ctrl_ff;
        end else if (widx == odp_pkg::REG_STAT && wb_adr_in[7:6] == 2'h0) begin
            nxt_rdat = status;
        end
    end

    // Output configuration registers, one word per output
    always_comb begin
        for (int i = 0; i < odp_pkg::NOUT; i++) begin
            nxt_cfg[i] = cfg_ff[i];
            if (wr_hit && widx == 4'(i)) begin
                nxt_cfg[i] = ((cfg_ff[i] & ~wmask) | (wb_dat_in & wmask))
                             & odp_pkg::CFG_MASK;
            end
        end
    end

    // Control register; the go bit is a pulse and never stored
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wr_hit && widx == odp_pkg::REG_CTRL) begin
            nxt_ctrl = ((ctrl_ff & ~wmask) | (wb_dat_in & wmask))
                       & odp_pkg::CTRL_MASK;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            for (int i = 0; i < odp_pkg::NOUT; i++) begin
                cfg_ff[i] <= odp_pkg::CFG_RST;
            end
            ctrl_ff <= odp_pkg::CTRL_RST;
            ack_ff  <= 1'b0;
            rdat_ff <= 32'h0000_0000;
        end else begin
            for (int i = 0; i < odp_pkg::NOUT; i++) begin
                cfg_ff[i] <= nxt_cfg[i];
            end
            ctrl_ff <= nxt_ctrl;
            ack_ff  <= nxt_ack;
            rdat_ff <= nxt_rdat;
        end
    end

    assign wb_ack_out = ack_ff;
    assign wb_dat_out = rdat_ff;

    // ------------------------------------------------------------
    // Source clock sampling and shared reset/hold pin
    // ------------------------------------------------------------
    // The nonvolatile select is caught while reset is held, so a
    // change on that strap during operation has no effect
    always_comb begin
        nxt_src_q = src_clk_in;
        nxt_pin_q = sync_pin_in;
        nxt_rhs   = resetn_in ? rhs_ff : nv_rh_sel_in;
        // Select high: shared pin is hold; low: reset
        nxt_hold  = rhs_ff & ~rst_hold_n_in;
        src_rise  = src_clk_in & ~src_q_ff;
        rst_req   = ~rhs_ff & ~rst_hold_n_in;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            src_q_ff <= 1'b0;
            pin_q_ff <= 1'b0;
            hold_ff  <= 1'b0;
        end else begin
            src_q_ff <= nxt_src_q;
            pin_q_ff <= nxt_pin_q;
            hold_ff  <= nxt_hold;
        end
        rhs_ff <= nxt_rhs;
    end

    assign hold_active_out = hold_ff;

    // ------------------------------------------------------------
    // Divider synchronisation
    // ------------------------------------------------------------
    // Source select picks software, sync pin edge, reset pin or any
    always_comb begin
        case (ctrl_ff[odp_pkg::SRC_LSB +: 2])
            odp_pkg::SRC_SW:  sync_req = sw_go;
            odp_pkg::SRC_PIN: sync_req = sync_pin_in & ~pin_q_ff;
            odp_pkg::SRC_RST: sync_req = rst_req;
            default:          sync_req = sw_go | (sync_pin_in & ~pin_q_ff) | rst_req;
        endcase
    end

    // Arm waits for the retime edge: any source rise, or the wrap of
    // divider zero when retiming is selected. The arm and hold steps wait on
    // source edges, so a stopped source clock leaves the block busy.
    always_comb begin
        nxt_sy   = sy_ff;
        load_ph  = 1'b0;
        div_held = 1'b0;
        case (sy_ff)
            odp_pkg::SY_IDLE: begin
                if (sync_req) begin
                    nxt_sy = odp_pkg::SY_ARM;
                end
            end
            odp_pkg::SY_ARM: begin
                if (src_rise && (!ctrl_ff[odp_pkg::RT_BIT] || wrap[0])) begin
                    nxt_sy = odp_pkg::SY_HOLD;
                end
            end
            odp_pkg::SY_HOLD: begin
                div_held = 1'b1;
                if (src_rise && !(rst_req && sync_req)) begin
                    load_ph = 1'b1;
                    nxt_sy  = odp_pkg::SY_IDLE;
                end
            end
            default: begin
                nxt_sy = odp_pkg::SY_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            sy_ff <= odp_pkg::SY_IDLE;
        end else begin
            sy_ff <= nxt_sy;
        end
    end

    // ------------------------------------------------------------
    // Output dividers
    // ------------------------------------------------------------
    // Divider d is programmed by register d+1; out0 and out9 reuse
    // the first and last divider instead of having their own
    for (genvar d = 0; d < odp_pkg::NDIV; d++) begin : g_div
        logic [4:0] rsel;
        logic [6:0] ph;
        logic [6:0] half;
        always_comb begin
            rsel = cfg_ff[d + 1][odp_pkg::RS_LSB +: 5];
            // Codes past the table fall back to bypass
            ratio[d] = (rsel < 5'(odp_pkg::NRATIO)) ?
                       odp_pkg::RATIO_TBL[rsel] : odp_pkg::RATIO_TBL[0];
            // A phase at or past the ratio is out of range: use zero
            ph = cfg_ff[d + 1][odp_pkg::PH_LSB +: 7];
            if (ph >= ratio[d]) begin
                ph = 7'h00;
            end
            half    = ratio[d] >> 1;
            wrap[d] = (cnt_ff[d] == ratio[d] - 7'h01);
            nxt_cnt[d]  = cnt_ff[d];
            nxt_dlvl[d] = dlvl_ff[d];
            if (load_ph) begin
                // Same source edge for every divider
                nxt_cnt[d] = ph;
            end else if (div_held) begin
                nxt_cnt[d] = 7'h00;
            end else if (src_rise) begin
                // One step per source cycle: 360/ratio degrees
                nxt_cnt[d] = wrap[d] ? 7'h00 : cnt_ff[d] + 7'h01;
            end
            if (ratio[d] == 7'h01) begin
                // Bypass: the counter plays no part
                nxt_dlvl[d] = src_clk_in;
            end else if (div_held) begin
                nxt_dlvl[d] = 1'b0;
            end else if (load_ph || src_rise) begin
                // Ratio two: phase 0 or 1 gives 0 or 180 degrees
                nxt_dlvl[d] = (nxt_cnt[d] < half);
            end
        end
        always_ff @(posedge sys_clk_in) begin
            if (!resetn_in) begin
                cnt_ff[d]  <= 7'h00;
                dlvl_ff[d] <= 1'b0;
            end else begin
                cnt_ff[d]  <= nxt_cnt[d];
                dlvl_ff[d] <= nxt_dlvl[d];
            end
        end
    end

    // ------------------------------------------------------------
    // Output buffers
    // ------------------------------------------------------------
    // Each output gets a divider level plus a driver selection; the
    // enables are exclusive by the type encoding
    for (genvar k = 0; k < odp_pkg::NOUT; k++) begin : g_out
        localparam int DIX = (k == 0) ? 0 : ((k == 9) ? 7 : k - 1);
        logic [1:0] dtyp;
        logic [1:0] cn;
        logic [1:0] cp;
        logic       lvl;
        logic       lvl_ff;
        logic       pe_ff;
        logic       le_ff;
        logic       sp_ff;
        logic       spo_ff;
        logic       sn_ff;
        logic       sno_ff;
        logic       nxt_lvl;
        logic       nxt_pe;
        logic       nxt_le;
        logic       nxt_sp;
        logic       nxt_spo;
        logic       nxt_sn;
        logic       nxt_sno;
        always_comb begin
            lvl     = dlvl_ff[DIX];
            dtyp    = cfg_ff[k][odp_pkg::DT_LSB +: 2];
            cn      = cfg_ff[k][odp_pkg::CN_LSB +: 2];
            cp      = cfg_ff[k][odp_pkg::CP_LSB +: 2];
            nxt_lvl = lvl;
            nxt_pe  = (dtyp == odp_pkg::DT_PECL);
            nxt_le  = (dtyp == odp_pkg::DT_LVDS);
            nxt_sp  = 1'b0;
            nxt_spo = 1'b0;
            nxt_sn  = 1'b0;
            nxt_sno = 1'b0;
            if (dtyp == odp_pkg::DT_CMOS) begin
                if (ctrl_ff[odp_pkg::ALT_BIT]) begin
                    // Alternate mode ignores both control pairs: each pin drives the level
                    nxt_sp  = lvl;
                    nxt_spo = 1'b1;
                    nxt_sn  = lvl;
                    nxt_sno = 1'b1;
                end else begin
                    // Each pin set by its own control pair; the high-impedance code turns it off
                    nxt_spo = (cp != odp_pkg::SE_HIZ);
                    nxt_sp  = (cp == odp_pkg::SE_ACT) ? lvl :
                              ((cp == odp_pkg::SE_INV) ? ~lvl : 1'b0);
                    nxt_sno = (cn != odp_pkg::SE_HIZ);
                    nxt_sn  = (cn == odp_pkg::SE_ACT) ? lvl :
                              ((cn == odp_pkg::SE_INV) ? ~lvl : 1'b0);
                end
            end
        end
        always_ff @(posedge sys_clk_in) begin
            if (!resetn_in) begin
                lvl_ff <= 1'b0;
                pe_ff  <= 1'b0;
                le_ff  <= 1'b0;
                sp_ff  <= 1'b0;
                spo_ff <= 1'b0;
                sn_ff  <= 1'b0;
                sno_ff <= 1'b0;
            end else begin
                lvl_ff <= nxt_lvl;
                pe_ff  <= nxt_pe;
                le_ff  <= nxt_le;
                sp_ff  <= nxt_sp;
                spo_ff <= nxt_spo;
                sn_ff  <= nxt_sn;
                sno_ff <= nxt_sno;
            end
        end
        assign clk_lvl_out[k] = lvl_ff;
        assign pecl_en_out[k] = pe_ff;
        assign lvds_en_out[k] = le_ff;
        assign se_p_out[k]    = sp_ff;
        assign se_p_oe_out[k] = spo_ff;
        assign se_n_out[k]    = sn_ff;
        assign se_n_oe_out[k] = sno_ff;
    end

endmodule

// >>> tb/odp_monitor.sv
// Port checker for the divider, phase and buffer block.
// Assumes it is bound to odp_top and sees its ports only.
`timescale 1ns/10ps
module odp_monitor (
    input wire logic        sys_clk_in,
    input wire logic        resetn_in,
    input wire logic        src_clk_in,
    input wire logic        rst_hold_n_in,
    input wire logic        wb_cyc_in,
    input wire logic        wb_stb_in,
    input wire logic        wb_we_in,
    input wire logic [7:0]  wb_adr_in,
    input wire logic [31:0] wb_dat_out,
    input wire logic        wb_ack_out,
    input wire logic [9:0]  clk_lvl_out,
    input wire logic [9:0]  pecl_en_out,
    input wire logic [9:0]  lvds_en_out,
    input wire logic [9:0]  se_p_oe_out,
    input wire logic [9:0]  se_n_oe_out,
    input wire logic        hold_active_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    logic rd_ack;
    // ----------------------------------------
    // Bus answers
    // ----------------------------------------
    // Read answer marker, address still held by master
    assign rd_ack = wb_ack_out && !wb_we_in;
    rst_quiet_a: assert property (disable iff (1'b0) !resetn_in |=> !wb_ack_out &&
        clk_lvl_out == 10'h000 && pecl_en_out == 10'h000 && se_p_oe_out == 10'h000)
        else $error("outputs not cleared by reset");
    ack_time_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
        else $error("ack not one cycle after request");
    ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack longer than one cycle");
    unmap_zero_a: assert property (rd_ack && wb_adr_in >= 8'h30 |-> wb_dat_out == 32'h0)
        else $error("unmapped read not zero");
    resv_zero_a: assert property (rd_ack && wb_adr_in < 8'h28 |->
        (wb_dat_out & ~odp_pkg::CFG_MASK) == 32'h0) else $error("reserved bits set");
    go_reads_zero_a: assert property (rd_ack && wb_adr_in == 8'h28 |-> !wb_dat_out[0])
        else $error("sync go bit read back");
    // ----------------------------------------
    // Clock outputs and drivers
    // ----------------------------------------
    one_driver_a: assert property ((pecl_en_out & lvds_en_out) == 10'h000 &&
        ((pecl_en_out | lvds_en_out) & (se_p_oe_out | se_n_oe_out)) == 10'h000)
        else $error("two driver kinds on one output");
    pair_share_a: assert property (clk_lvl_out[0] == clk_lvl_out[1] &&
        clk_lvl_out[9] == clk_lvl_out[8]) else $error("paired output differs");
    src_step_a: assert property ($rose(clk_lvl_out[1]) |->
        $past(src_clk_in, 2) || $past(src_clk_in, 3)) else $error("edge off source step");
    hold_cause_a: assert property (hold_active_out |->
        !$past(rst_hold_n_in) || !$past(rst_hold_n_in, 2)) else $error("hold without pin");
    pecl_seen_c: cover property (pecl_en_out[0]);
    se_seen_c: cover property (se_p_oe_out[2] && se_n_oe_out[2]);
    hold_seen_c: cover property (hold_active_out);
endmodule
bind odp_top odp_monitor odp_monitor_inst (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .src_clk_in(src_clk_in),
    .rst_hold_n_in(rst_hold_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .clk_lvl_out(clk_lvl_out), .pecl_en_out(pecl_en_out),
    .lvds_en_out(lvds_en_out), .se_p_oe_out(se_p_oe_out), .se_n_oe_out(se_n_oe_out),
    .hold_active_out(hold_active_out)
);

// >>> tb/odp_rx_model.sv
// Downstream clock receivers: time every rising edge per output.
// Assumes levels settle between system clock edges.
`timescale 1ns/10ps
module odp_rx_model (
    input  wire logic       sys_clk_in,
    input  wire logic [9:0] clk_lvl_in,
    output int              per_out  [10],
    output int              rise_out [10]
);
    int         now;
    logic [9:0] prev;
    // Start from a known time base
    initial begin
        now = 0;
        prev = 10'h000;
        for (int i = 0; i < 10; i++) begin
            per_out[i] = 0;
            rise_out[i] = 0;
        end
    end
    // Period and last edge per receiver
    always @(posedge sys_clk_in) begin
        now <= now + 1;
        prev <= clk_lvl_in;
        for (int i = 0; i < 10; i++) begin
            if (clk_lvl_in[i] && !prev[i]) begin
                per_out[i] <= now - rise_out[i];
                rise_out[i] <= now;
            end
        end
    end
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the divider block over Wishbone.
// Assumes a source clock of one eighth the system clock rate.
`timescale 1ns/10ps
module testbench;
    logic        sys_clk_in = 1'b0;
    logic        resetn = 1'b0;
    logic        src_clk = 1'b0;
    logic        sync_pin = 1'b0;
    logic        rh_n = 1'b1;
    logic        nv_sel = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic [9:0]  lvl, pecl, lvds, sp, spoe, sn, snoe;
    logic        hold;
    logic [2:0]  sc = 3'h0;
    logic [31:0] q;
    int          per [10];
    int          rise [10];
    int          err_total = 0;
    int          n_tests = 0;
    int          cyc_n = 0;
    int          rt [8] = '{1, 2, 3, 4, 8, 16, 42, 80};
    int          cd [8] = '{0, 1, 2, 3, 6, 9, 18, 25};

    odp_top odp_top_inst (.sys_clk_in(sys_clk_in), .resetn_in(resetn), .src_clk_in(src_clk),
        .sync_pin_in(sync_pin), .rst_hold_n_in(rh_n), .nv_rh_sel_in(nv_sel),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(4'hF), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
        .clk_lvl_out(lvl), .pecl_en_out(pecl), .lvds_en_out(lvds), .se_p_out(sp),
        .se_p_oe_out(spoe), .se_n_out(sn), .se_n_oe_out(snoe), .hold_active_out(hold));
    odp_rx_model odp_rx_model_inst (.sys_clk_in(sys_clk_in), .clk_lvl_in(lvl),
        .per_out(per), .rise_out(rise));

    // ----------------------------------------
    // Clocks and watchdog
    // ----------------------------------------
    // System clock, 50 ns period
    always #25 sys_clk_in = ~sys_clk_in;
    // Source clock at one eighth, slow enough for level sampling
    always @(posedge sys_clk_in) begin
        sc <= sc + 3'h1;
        src_clk <= sc[2];
    end
    // Hang guard well above the planned run
    always @(posedge sys_clk_in) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            err_total++;
            close_out;
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic close_out;
        if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // One classic cycle, held until ack is sampled
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r);
        adr <= a;
        we <= w;
        wdat <= d;
        cyc <= 1'b1;
        stb <= 1'b1;
        @(posedge sys_clk_in);
        while (ack !== 1'b1) @(posedge sys_clk_in);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge sys_clk_in);
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    // Poll status until the sync sequence is over
    task automatic wait_idle;
        logic [31:0] s;
        s = 32'h1;
        while (s[0] === 1'b1) bus(8'h2C, 1'b0, 32'h0, s);
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge sys_clk_in);
        resetn <= 1'b1;
        @(posedge sys_clk_in);
        // Reset values, masks, unmapped place, stored select
        bus(8'h04, 1'b0, 32'h0, q);
        chk("cfg1 rst", odp_pkg::CFG_RST, q);
        bus(8'h0C, 1'b1, 32'hFFFF_FFFF, q);
        bus(8'h0C, 1'b0, 32'h0, q);
        chk("cfg3 mask", odp_pkg::CFG_MASK, q);
        bus(8'h40, 1'b1, 32'hFFFF_FFFF, q);
        bus(8'h40, 1'b0, 32'h0, q);
        chk("unmapped", 32'h0, q);
        bus(8'h2C, 1'b0, 32'h0, q);
        chk("nv sel", 32'h2, q & 32'h2);
        // Eight ratios from bypass to the largest, after a software sync
        for (int i = 0; i < 8; i++) bus(8'(4 * (i + 1)), 1'b1, 32'(cd[i]), q);
        bus(8'h28, 1'b1, 32'h1, q);
        wait_idle;
        repeat (1400) @(posedge sys_clk_in);
        for (int i = 0; i < 8; i++) chk("period", 32'(8 * rt[i]), 32'(per[i + 1]));
        chk("out0 period", 32'(per[1]), 32'(per[0]));
        chk("out9 period", 32'(per[8]), 32'(per[9]));
        // Coarse phase: quarter steps at four, half period at two
        bus(8'h04, 1'b1, 32'h03, q);
        bus(8'h08, 1'b1, 32'h23, q);
        bus(8'h0C, 1'b1, 32'h21, q);
        bus(8'h10, 1'b1, 32'h01, q);
        bus(8'h28, 1'b1, 32'h1, q);
        wait_idle;
        repeat (100) @(posedge sys_clk_in);
        chk("ph quarter", 32'h18, 32'(((rise[2] - rise[1]) % 32 + 32) % 32));
        chk("ph half", 32'h08, 32'(((rise[3] - rise[4]) % 16 + 16) % 16));
        // Driver kinds and single-ended controls
        bus(8'h00, 1'b1, 32'h0000_1000, q);
        bus(8'h04, 1'b1, 32'h0000_2000, q);
        bus(8'h08, 1'b1, 32'h0000_3000, q);
        bus(8'h0C, 1'b1, 32'h0000_0000, q);
        bus(8'h10, 1'b1, 32'h0380_3000, q);
        repeat (2) @(posedge sys_clk_in);
        chk("pecl en", 32'h01, {27'h0, pecl[4:0]});
        chk("lvds en", 32'h02, {27'h0, lvds[4:0]});
        chk("se p oe", 32'h04, {27'h0, spoe[4:0]});
        chk("se n oe", 32'h14, {27'h0, snoe[4:0]});
        chk("se n low", 32'h0, {31'h0, sn[4]});
        chk("se pair", {31'h0, sp[2]}, {31'h0, sn[2]});
        bus(8'h08, 1'b1, 32'h0100_3000, q);
        repeat (2) @(posedge sys_clk_in);
        chk("se p inv", {31'h0, ~sn[2]}, {31'h0, sp[2]});
        bus(8'h28, 1'b1, 32'h10, q);
        repeat (2) @(posedge sys_clk_in);
        chk("alt p oe", 32'h1, {31'h0, spoe[4]});
        // Pin sync source with retiming, then the hold pin
        bus(8'h28, 1'b1, 32'h0A, q);
        sync_pin <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        bus(8'h2C, 1'b0, 32'h0, q);
        chk("pin busy", 32'h1, q & 32'h1);
        sync_pin <= 1'b0;
        wait_idle;
        rh_n <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        chk("hold", 32'h1, {31'h0, hold});
        rh_n <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        // Second reset with the strap low: shared pin acts as reset
        nv_sel <= 1'b0;
        resetn <= 1'b0;
        repeat (3) @(posedge sys_clk_in);
        resetn <= 1'b1;
        @(posedge sys_clk_in);
        bus(8'h2C, 1'b0, 32'h0, q);
        chk("nv sel low", 32'h0, q & 32'h2);
        bus(8'h28, 1'b1, 32'h04, q);
        rh_n <= 1'b0;
        repeat (20) @(posedge sys_clk_in);
        bus(8'h2C, 1'b0, 32'h0, q);
        chk("rst pin busy", 32'h1, q & 32'h5);
        rh_n <= 1'b1;
        wait_idle;
        close_out;
    end
endmodule
